/* File: verilog/bcbr_defines.svh */
// constants for the branch, call, bit-set and reset executor
`ifndef BCBR_DEFINES_SVH
`define BCBR_DEFINES_SVH
`define BCBR_PC_W        21
`define BCBR_OPC_JMP     4'hD
`define BCBR_OPC_BSET    4'h8
`define BCBR_RESET_WORD  16'h00FF
`define BCBR_OFF_MSB     10
`define BCBR_CALL_BIT    11
`define BCBR_PC_STEP     21'h000002
`define BCBR_PC_RESET    21'h000000
`define BCBR_Q_LAST      2'h3
`define BCBR_Q_FIRST     2'h0
`define BCBR_Q_DECODE    2'h0
`define BCBR_Q_READ      2'h1
`define BCBR_Q_WRITE     2'h3
`define BCBR_Q_PROC      2'h2
`define BCBR_OPC_MSB     15
`define BCBR_OPC_LSB     12
`define BCBR_BIT_MSB     11
`define BCBR_BIT_LSB     9
`define BCBR_BANK_BIT    8
`define BCBR_F_MSB       7
`endif

/* File: verilog/bcbr_pkg.sv */
// types for the branch, call, bit-set and reset executor
package bcbr_pkg;
  typedef enum logic [1:0] {
    BCBR_ST_EXEC  = 2'b00,
    BCBR_ST_FLUSH = 2'b01
  } bcbr_state_t;
  typedef enum logic [2:0] {
    BCBR_OP_NONE  = 3'b000,
    BCBR_OP_BRA   = 3'b001,
    BCBR_OP_CALL  = 3'b010,
    BCBR_OP_BSET  = 3'b011,
    BCBR_OP_RESET = 3'b100
  } bcbr_op_t;
endpackage

/* File: verilog/bcbr_phase_if.sv */
// quarter-phase signals shared between the sequencer and the executor
`timescale 1ns/100ps
interface bcbr_phase_if;
  logic [1:0] q_phase;
  logic       cyc_end;
  modport gen (output q_phase, output cyc_end);
  modport use_p (input q_phase, input cyc_end);
endinterface

/* File: verilog/bcbr_qgen.sv */
// quarter-phase sequencer: four clocks per instruction cycle
`timescale 1ns/100ps
`include "bcbr_defines.svh"
module bcbr_qgen (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  bcbr_phase_if.gen ph
);
  logic [1:0] q_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q_reg <= `BCBR_Q_FIRST;
    end else begin
      q_reg <= q_reg + 2'h1;
    end
  end
  assign ph.q_phase = q_reg;
  assign ph.cyc_end = (q_reg == `BCBR_Q_LAST);
  // a_phase_wrap
  a_phase_wrap: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (q_reg == `BCBR_Q_LAST) |=> (q_reg == `BCBR_Q_FIRST) ##3
    (q_reg == `BCBR_Q_LAST))
    else $error("quarter phase does not wrap after four clocks");
endmodule // bcbr_qgen

/* File: verilog/bcbr_exec.sv */
// decode and execute for branch, call, bit-set and software reset
`timescale 1ns/100ps
`include "bcbr_defines.svh"
module bcbr_exec
  import bcbr_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic                  master_clear_pin_n,
  input  wire logic [15:0]           instr_word,
  input  wire logic                  instr_valid,
  input  wire logic [7:0]            file_rdata,
  output logic      [`BCBR_PC_W-1:0] pc,
  output logic                       fetch_req,
  output logic      [7:0]            file_addr,
  output logic                       file_rd,
  output logic                       file_access_bank,
  output logic                       file_we,
  output logic      [7:0]            file_wdata,
  output logic                       stack_push,
  output logic      [`BCBR_PC_W-1:0] top_of_return_stack,
  output logic                       soft_reset,
  output logic      [1:0]            q_phase,
  output logic                       flush_cycle
);
  bcbr_phase_if ph ();
  bcbr_qgen u_qgen (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .ph      (ph)
  );

  function automatic logic [`BCBR_PC_W-1:0] rel_target(
    input logic [`BCBR_PC_W-1:0] base,
    input logic [15:0]           iw
  );
    logic [`BCBR_PC_W-1:0] off;
    off = {{(`BCBR_PC_W-`BCBR_OFF_MSB-2){iw[`BCBR_OFF_MSB]}},
           iw[`BCBR_OFF_MSB:0], 1'b0};
    rel_target = base + `BCBR_PC_STEP + off;
  endfunction

  function automatic bcbr_op_t decode(input logic [15:0] iw);
    if (iw == `BCBR_RESET_WORD)
      decode = BCBR_OP_RESET;
    else if (iw[`BCBR_OPC_MSB:`BCBR_OPC_LSB] == `BCBR_OPC_JMP)
      decode = iw[`BCBR_CALL_BIT] ? BCBR_OP_CALL : BCBR_OP_BRA;
    else if (iw[`BCBR_OPC_MSB:`BCBR_OPC_LSB] == `BCBR_OPC_BSET)
      decode = BCBR_OP_BSET;
    else
      decode = BCBR_OP_NONE;
  endfunction

  bcbr_state_t           state_reg;
  bcbr_op_t              op_reg;
  logic [15:0]           iw_reg;
  logic [`BCBR_PC_W-1:0] pc_reg;
  logic [`BCBR_PC_W-1:0] tos_reg;
  logic                  push_reg;
  logic                  fetch_reg;
  logic                  rd_reg;
  logic                  we_reg;
  logic [7:0]            wdata_reg;
  logic                  srst_reg;
  logic [1:0]            q_reg;
  logic                  flush_reg;
  logic                  bank_reg;
  // master clear and the reset instruction share one restore path
  logic                  master_clear_pin_hit;

  assign master_clear_pin_hit = !master_clear_pin_n || srst_reg;

  // latch the word at decode; bus holds it only during the first quarter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      iw_reg <= 16'h0000;
      op_reg <= BCBR_OP_NONE;
    end else if (master_clear_pin_hit) begin
      iw_reg <= 16'h0000;
      op_reg <= BCBR_OP_NONE;
    end else if (ph.q_phase == `BCBR_Q_DECODE) begin
      if (instr_valid && state_reg == BCBR_ST_EXEC) begin
        iw_reg <= instr_word;
        op_reg <= decode(instr_word);
      end else begin
        op_reg <= BCBR_OP_NONE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= BCBR_ST_EXEC;
      flush_reg <= 1'b0;
    end else if (master_clear_pin_hit) begin
      state_reg <= BCBR_ST_EXEC;
      flush_reg <= 1'b0;
    end else if (ph.cyc_end) begin
      case (state_reg)
        BCBR_ST_EXEC: begin
          if (op_reg == BCBR_OP_BRA || op_reg == BCBR_OP_CALL) begin
            state_reg <= BCBR_ST_FLUSH;
            flush_reg <= 1'b1;
          end
        end
        BCBR_ST_FLUSH: begin
          state_reg <= BCBR_ST_EXEC;
          flush_reg <= 1'b0;
        end
        default: begin
          state_reg <= BCBR_ST_EXEC;
          flush_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tos_reg  <= `BCBR_PC_RESET;
      push_reg <= 1'b0;
    end else if (master_clear_pin_hit) begin
      tos_reg  <= `BCBR_PC_RESET;
      push_reg <= 1'b0;
    end else if (ph.q_phase == `BCBR_Q_READ && op_reg == BCBR_OP_CALL &&
                 state_reg == BCBR_ST_EXEC) begin
      tos_reg  <= pc_reg + `BCBR_PC_STEP;
      push_reg <= 1'b1;
    end else begin
      push_reg <= 1'b0;
    end
  end

  // pc written in the last quarter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg    <= `BCBR_PC_RESET;
      fetch_reg <= 1'b0;
    end else if (master_clear_pin_hit) begin
      pc_reg    <= `BCBR_PC_RESET;
      fetch_reg <= 1'b0;
    end else if (ph.cyc_end) begin
      fetch_reg <= 1'b1;
      if ((op_reg == BCBR_OP_BRA || op_reg == BCBR_OP_CALL) &&
          state_reg == BCBR_ST_EXEC)
        pc_reg <= rel_target(pc_reg, iw_reg);
      else if (state_reg == BCBR_ST_EXEC)
        pc_reg <= pc_reg + `BCBR_PC_STEP;
    end else begin
      fetch_reg <= 1'b0;
    end
  end

  // read, set bit, write back; no flags touched
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_reg    <= 1'b0;
      we_reg    <= 1'b0;
      wdata_reg <= 8'h00;
      bank_reg  <= 1'b0;
    end else if (master_clear_pin_hit) begin
      rd_reg    <= 1'b0;
      we_reg    <= 1'b0;
      wdata_reg <= 8'h00;
      bank_reg  <= 1'b0;
    end else begin
      // strobe on the decode edge itself, so data is back by the process
      // quarter; op_reg still holds the previous word at that edge
      rd_reg   <= (ph.q_phase == `BCBR_Q_DECODE) && instr_valid &&
                  (state_reg == BCBR_ST_EXEC) &&
                  (decode(instr_word) == BCBR_OP_BSET);
      bank_reg <= iw_reg[`BCBR_BANK_BIT];
      we_reg   <= (op_reg == BCBR_OP_BSET) &&
                  (ph.q_phase == `BCBR_Q_PROC);
      if (op_reg == BCBR_OP_BSET && ph.q_phase == `BCBR_Q_PROC)
        wdata_reg <= file_rdata |
                     (8'h01 << iw_reg[`BCBR_BIT_MSB:`BCBR_BIT_LSB]);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      srst_reg <= 1'b0;
    end else begin
      srst_reg <= !srst_reg && op_reg == BCBR_OP_RESET &&
                  ph.q_phase == `BCBR_Q_READ;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q_reg <= `BCBR_Q_FIRST;
    end else begin
      q_reg <= ph.q_phase;
    end
  end

  assign pc                  = pc_reg;
  assign fetch_req           = fetch_reg;
  assign file_addr           = iw_reg[`BCBR_F_MSB:0];
  assign file_rd             = rd_reg;
  assign file_access_bank    = bank_reg;
  assign file_we             = we_reg;
  assign file_wdata          = wdata_reg;
  assign stack_push          = push_reg;
  assign top_of_return_stack = tos_reg;
  assign soft_reset          = srst_reg;
  assign q_phase             = q_reg;
  assign flush_cycle         = flush_reg;

  a_call_push_val: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(push_reg) |-> tos_reg == $past(pc_reg) + `BCBR_PC_STEP)
    else $error("pushed return address is not pc plus two");
  a_call_push_first: assert property (
    @(posedge clk_sys) disable iff (!arst_n || master_clear_pin_hit)
    push_reg |-> (pc_reg == $past(pc_reg)) ##[1:3] fetch_reg)
    else $error("pc changed before the push");
  a_flush_two_cyc: assert property (
    @(posedge clk_sys) disable iff (!arst_n || master_clear_pin_hit)
    $rose(flush_reg) |-> flush_reg [*4] ##1 !flush_reg)
    else $error("branch or call second cycle is not one cycle");
  a_flush_no_push: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    flush_reg |-> !push_reg && !we_reg && !rd_reg)
    else $error("activity during the idle cycle");
  a_bset_write: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(we_reg) |-> wdata_reg == ($past(file_rdata) |
      (8'h01 << iw_reg[`BCBR_BIT_MSB:`BCBR_BIT_LSB])))
    else $error("bit set result wrong");
  a_bset_seq: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(rd_reg) |-> ##2 we_reg)
    else $error("bit set write does not follow read");
  a_srst_clear: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    srst_reg |=> pc_reg == `BCBR_PC_RESET && !srst_reg)
    else $error("reset instruction did not restore state");
  a_rel_target: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (ph.cyc_end && !master_clear_pin_hit && state_reg == BCBR_ST_EXEC &&
     (op_reg == BCBR_OP_BRA || op_reg == BCBR_OP_CALL)) |=>
    pc_reg == $past(pc_reg) + `BCBR_PC_STEP +
      {{(`BCBR_PC_W-`BCBR_OFF_MSB-2){$past(iw_reg[`BCBR_OFF_MSB])}},
       $past(iw_reg[`BCBR_OFF_MSB:0]), 1'b0})
    else $error("relative target wrong");
endmodule // bcbr_exec

/* File: test/bcbr_regfile_model.sv */
// register file model behind the bit-set read and write strobes
`timescale 1ns/100ps
module bcbr_regfile_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] file_addr,
  input  wire logic       file_rd,
  input  wire logic       file_we,
  input  wire logic [7:0] file_wdata,
  output logic      [7:0] file_rdata
);
  logic [7:0] mem [256];
  logic       hold_reg = 1'b0;
  logic [7:0] last_reg = 8'h00;
  always @(posedge clk_sys) begin
    hold_reg <= file_rd;
    if (file_rd | hold_reg)
      last_reg <= file_rdata;
    if (file_we)
      mem[file_addr] <= file_wdata;
  end
  // outside the read window the bus carries junk, not stale data
  always_comb begin
    if (file_rd | hold_reg)
      file_rdata = mem[file_addr];
    else
      file_rdata = ~last_reg;
  end
endmodule // bcbr_regfile_model

/* File: test/testbench.sv */
// self-checking bench for the branch, call, bit-set and reset executor
`timescale 1ns/100ps
`include "bcbr_defines.svh"
module testbench;
  import bcbr_pkg::*;
  typedef struct {int kind; logic [20:0] val; int due;} bcbr_note_t;
  logic clk_sys = 1'b0, arst_n = 1'b0, master_clear_pin_n = 1'b0;
  logic instr_valid = 1'b0, file_rd, file_bank, file_we, stack_push;
  logic fetch_req, soft_reset, flush_cycle;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0] file_rdata, file_addr, file_wdata;
  logic [`BCBR_PC_W-1:0] pc, top_of_return_stack;
  logic [1:0] q_phase;
  logic [31:0] seed = 32'h00006DEC;
  bcbr_note_t notes[$];
  int err_total = 0, num_checks = 0, cyc = 0;
  int offs[4] = '{0, 1023, -1024, 5};
  always #4 clk_sys = ~clk_sys;
  bcbr_exec u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .master_clear_pin_n(master_clear_pin_n), .instr_word(instr_word),
    .instr_valid(instr_valid), .file_rdata(file_rdata), .pc(pc),
    .fetch_req(fetch_req), .file_addr(file_addr), .file_rd(file_rd),
    .file_access_bank(file_bank), .file_we(file_we),
    .file_wdata(file_wdata), .stack_push(stack_push),
    .top_of_return_stack(top_of_return_stack), .soft_reset(soft_reset),
    .q_phase(q_phase), .flush_cycle(flush_cycle));
  bcbr_regfile_model u_reg (.clk_sys(clk_sys), .file_addr(file_addr),
    .file_rd(file_rd), .file_we(file_we), .file_wdata(file_wdata),
    .file_rdata(file_rdata));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input int k, input logic [20:0] v);
    bcbr_note_t n;
    n = notes.pop_front();
    num_checks++;
    if (n.kind != k || v !== n.val) begin
      err_total++;
      $display("mismatch %0t kind %0d got %h want %h", $time, k, v, n.val);
    end
  endtask
  // results are taken one edge after the design registers them
  always @(posedge clk_sys) begin
    cyc++;
    if (notes.size() > 0 && stack_push === 1'b1)
      chk(0, top_of_return_stack);
    if (notes.size() > 0 && file_we === 1'b1)
      chk(1, {4'h0, file_bank, file_addr, file_wdata});
    if (notes.size() > 0 && fetch_req === 1'b1 && cyc >= notes[0].due)
      chk(2, pc);
    if (fetch_req === 1'b1) begin
      num_checks++;
      // pc is handed on only after the last quarter
      if (q_phase !== `BCBR_Q_LAST) begin
        err_total++;
        $display("mismatch %0t fetch outside last quarter", $time);
      end
    end
  end
  // held master clear parks pc at zero until the take edge
  task automatic issue(input logic [15:0] w, input logic master_clear_pin);
    int i;
    @(posedge clk_sys);
    master_clear_pin_n <= !master_clear_pin;
    repeat (4) @(posedge clk_sys);
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (q_phase === 2'h2 && flush_cycle === 1'b0)
        break;
    end
    if (i == 40) begin
      err_total++;
      $display("mismatch %0t no slot for instruction", $time);
      close_out();
    end else begin
      master_clear_pin_n <= 1'b1;
      instr_word <= w;
      instr_valid <= 1'b1;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
    end
  endtask
  task automatic note(input int k, input logic [20:0] v);
    notes.push_back('{k, v, cyc + 4});
  endtask
  task automatic drain(input string name);
    int i;
    for (i = 0; i < 60 && notes.size() > 0; i++)
      @(posedge clk_sys);
    if (notes.size() > 0) begin
      err_total++;
      $display("mismatch %0t %s stalled", $time, name);
      close_out();
    end else begin
      $display("test %s done", name);
    end
  endtask
  initial begin
    int k;
    int n;
    logic [7:0] f, d;
    logic       bank_sel;
    offs[3] = int'(rnd() % 2048) - 1024;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    foreach (offs[j]) begin
      n = offs[j];
      fork
        issue({`BCBR_OPC_JMP, 1'b0, n[10:0]}, 1'b1);
        #1 note(2, 21'(2 + 2 * n));
      join
      drain("branch");
      fork
        issue({`BCBR_OPC_JMP, 1'b1, n[10:0]}, 1'b1);
        #1 note(0, 21'h000002);
      join
      note(2, 21'(2 + 2 * n));
      drain("call");
    end
    for (k = 0; k < 8; k++) begin
      f = 8'(rnd());
      d = (k == 7) ? 8'h0A : 8'(rnd());
      bank_sel = 1'(rnd());
      u_reg.mem[f] = d;
      fork
        issue({`BCBR_OPC_BSET, 3'(k), bank_sel, f}, 1'b1);
        #1 note(1, {4'h0, bank_sel, f, d | (8'h01 << k)});
      join
      note(2, 21'h000002);
      drain("bitset");
    end
    issue({`BCBR_OPC_JMP, 1'b0, 11'h064}, 1'b1);
    repeat (12) @(posedge clk_sys);
    issue(`BCBR_RESET_WORD, 1'b0);
    for (k = 0; k < 8 && soft_reset !== 1'b1; k++)
      @(posedge clk_sys);
    // pc is cleared one edge after the pulse; the next cycle end steps it
    @(posedge clk_sys);
    num_checks++;
    // pc back at its cleared value
    if (k == 8 || pc !== `BCBR_PC_RESET) begin
      err_total++;
      $display("mismatch %0t soft reset left pc %h", $time, pc);
    end
    $display("test reset done");
    close_out();
  end
endmodule // testbench
